// File: common/rscf_pkg.sv
package rscf_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [3:0] OFS_CAUSE = 4'h0;
  localparam logic [3:0] OFS_EVT_STATUS = 4'h4;
  localparam logic [3:0] OFS_EVT_MASK = 4'h8;
  localparam logic [3:0] OFS_SCRATCH = 4'hC;
  // Cause register field positions
  localparam int B_TRAP = 15;
  localparam int B_ILLOP = 14;
  localparam int B_SBOR = 13;
  localparam int B_CM = 9;
  localparam int B_PROGMEM_SLEEP_POWER = 8;
  localparam int B_EXTERNAL_PIN_FLAG = 7;
  localparam int B_SWR = 6;
  localparam int B_SOFT_WATCHDOG_ENABLE = 5;
  localparam int B_WATCHDOG_TIMEOUT_FLAG = 4;
  localparam int B_SLEEP = 3;
  localparam int B_IDLE = 2;
  localparam int B_BOR = 1;
  localparam int B_POR = 0;
  // Implemented cause bits; bits 12 to 10 read as zero
  localparam logic [15:0] CAUSE_IMPL = 16'hE3FF;
  // Cause value left by a power-on reset
  localparam logic [15:0] CAUSE_POR_VALUE = 16'h0003;
  // Event status bit positions
  localparam int E_EXT = 0;
  localparam int E_INSTR = 1;
  localparam int E_WDT = 2;
  localparam int E_BOR = 3;
  localparam int E_TRAP = 4;
  localparam int E_ILLOP = 5;
  localparam int E_UWR = 6;
  localparam int E_CM = 7;
  localparam int EVT_W = 8;
  localparam logic [EVT_W-1:0] EVT_ZERO = 8'h00;
  // Brown-out configuration field codes
  localparam logic [1:0] BROWNOUT_CONFIG_FIELD_OFF = 2'h0;
  localparam logic [1:0] BROWNOUT_CONFIG_FIELD_SW = 2'h1;
  localparam logic [1:0] BROWNOUT_CONFIG_FIELD_NOSLEEP = 2'h2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] DATA_ZERO = 32'h00000000;
  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;
endpackage : rscf_pkg

// File: design/rscf_top.sv
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
// What this block does
// [RL1] Any active source asserts the system reset
// [RL2] Eight reset sources feed the combiner
// [RL3] Each reset sets a cause flag; opcode and register faults share one
// [RL4] Power-on clears causes, sets brown-out and power-on
// [RL5] Software sets/clears flags; never causes reset
// [RL6] Unreset storage survives every non power-on reset
// [RL7] Trap, opcode, mismatch, pin, instruction flags sticky
// [RL8] Watchdog flag cleared by power-saving or power-on
// [RL9] Sleep entry sets the sleep flag
// [RL10] Idle entry sets the idle flag
// [RL11] Brown-out flag set by brown-out and power-on
// [RL12] Power-on flag set only by power-on or a software write
// [RL13] Brown-out enable bit forced zero unless configured
// [RL14] Watchdog fuse high keeps watchdog always on
// [RL15] Only field 01 lets software switch brown-out
// [RL16] Pin sources synchronised before releasing reset
module rscf_top
  import rscf_pkg::*;
(
  input wire logic CLK, // System clock, 40 MHz
  input wire logic RSTN, // Power-on reset, synchronous, active low
  input wire logic EXT_PIN_RESET_N, // External reset pin, asynchronous, active low
  input wire logic BROWNOUT_DETECT, // Brown-out comparator, asynchronous, active high
  input wire logic RESET_INSTR, // Reset instruction executed
  input wire logic WDT_TIMEOUT, // Watchdog time-out
  input wire logic TRAP_CONFLICT, // Trap conflict
  input wire logic ILLEGAL_OPCODE, // Illegal opcode
  input wire logic UNINIT_WREG, // Uninitialised working register use
  input wire logic CONFIG_MISMATCH, // Configuration word mismatch
  input wire logic POWER_SAVING_INSTRUCTION_SLEEP, // Power-saving instruction entering Sleep
  input wire logic POWER_SAVING_INSTRUCTION_IDLE, // Power-saving instruction entering Idle
  input wire logic WAKEUP, // Wake-up from Sleep
  input wire logic WATCHDOG_CONFIG_FUSE, // Watchdog fuse, one forces watchdog on
  input wire logic [1:0] BROWNOUT_CONFIG_FIELD, // Brown-out configuration field
  output logic SYSTEM_RESET_OUT, // Combined system reset, active high
  output logic WATCHDOG_ENABLE, // Watchdog run enable
  output logic BROWNOUT_ENABLE, // Brown-out detector enable
  output logic PROGMEM_SLEEP_POWER, // Program memory bias in Sleep
  output logic IRQ, // Level interrupt
  input wire logic [3:0] AWADDR, // Write address
  input wire logic AWVALID, // Write address valid
  output logic AWREADY, // Write address ready
  input wire logic [31:0] WDATA, // Write data
  input wire logic [3:0] WSTRB, // Write byte strobes
  input wire logic WVALID, // Write data valid
  output logic WREADY, // Write data ready
  output logic [1:0] BRESP, // Write response
  output logic BVALID, // Write response valid
  input wire logic BREADY, // Write response ready
  input wire logic [3:0] ARADDR, // Read address
  input wire logic ARVALID, // Read address valid
  output logic ARREADY, // Read address ready
  output logic [31:0] RDATA, // Read data
  output logic [1:0] RRESP, // Read response
  output logic RVALID, // Read data valid
  input wire logic RREADY // Read data ready
);
  import rscf_pkg::*;

  logic [SYNC_STAGES-1:0] pin_sync; // Pin reset synchroniser, active high
  logic [SYNC_STAGES-1:0] bor_sync; // Brown-out synchroniser
  logic ext_evt; // Synchronised pin reset
  logic bor_evt; // Qualified brown-out reset
  logic any_src; // Any reset source active
  logic [EVT_W-1:0] evt_vec; // Source events, one per status bit
  logic [15:0] cause; // Reset cause register
  logic [EVT_W-1:0] evt_status; // Sticky event status
  logic [EVT_W-1:0] evt_mask; // Event interrupt mask
  logic [31:0] scratch; // Unreset scratch word
  logic in_sleep; // Device is in Sleep
  logic [3:0] aw_addr; // Held write address
  logic aw_held; // Write address taken
  logic [31:0] w_data; // Held write data
  logic [3:0] w_strb; // Held write strobes
  logic w_held; // Write data taken
  logic do_write; // Both halves present
  logic [15:0] wmask16; // Strobe mask for 16-bit registers
  logic [31:0] wmask32; // Strobe mask for 32-bit registers
  logic [15:0] next_cause; // Cause after this cycle
  logic [EVT_W-1:0] next_status; // Status after this cycle

  // Byte strobes expanded to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    logic [31:0] m;
    m = DATA_ZERO;
    for (int i = 0; i < 4; i++)
    begin
      m[8*i +: 8] = {8{s[i]}};
    end
    return m;
  endfunction : strb_mask

  // True when the brown-out bit is under software control
  function automatic logic sw_bor(input logic [1:0] f);
    return f == BROWNOUT_CONFIG_FIELD_SW;
  endfunction : sw_bor

  // Two flops per pin before anything reads it; only the last stage is used
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      pin_sync <= '0;
      bor_sync <= '0;
    end
    else
    begin
      pin_sync <= {pin_sync[0], ~EXT_PIN_RESET_N}; // RL16
      bor_sync <= {bor_sync[0], BROWNOUT_DETECT}; // RL16
    end
  end

  assign ext_evt = pin_sync[SYNC_STAGES-1];
  // Brown-out only counts while the detector is enabled
  assign bor_evt = bor_sync[SYNC_STAGES-1] & BROWNOUT_ENABLE;
  assign evt_vec = {CONFIG_MISMATCH, UNINIT_WREG, ILLEGAL_OPCODE, TRAP_CONFLICT,
                    bor_evt, WDT_TIMEOUT, RESET_INSTR, ext_evt}; // RL2
  assign any_src = |evt_vec; // RL1

  // Combined reset; held during power-on, registered so it is glitch-free
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      SYSTEM_RESET_OUT <= 1'b1; // RL1
    end
    else
    begin
      SYSTEM_RESET_OUT <= any_src; // RL1
    end
  end

  // Sleep tracking, used by the sleep-gated brown-out mode
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      in_sleep <= 1'b0;
    end
    else if (POWER_SAVING_INSTRUCTION_SLEEP)
    begin
      in_sleep <= 1'b1;
    end
    else if (WAKEUP || any_src)
    begin
      in_sleep <= 1'b0;
    end
  end

  assign do_write = aw_held & w_held & ~BVALID;
  assign wmask32 = strb_mask(w_strb);
  assign wmask16 = wmask32[15:0];

  // Cause: software write first, hardware clears next, hardware sets last
  always_comb
  begin
    next_cause = cause;
    if (do_write && aw_addr == OFS_CAUSE)
    begin
      next_cause = (cause & ~wmask16) | (w_data[15:0] & wmask16); // RL5
    end
    if (POWER_SAVING_INSTRUCTION_SLEEP || POWER_SAVING_INSTRUCTION_IDLE)
    begin
      next_cause[B_WATCHDOG_TIMEOUT_FLAG] = 1'b0; // RL8
    end
    if (SYSTEM_RESET_OUT && !any_src && sw_bor(BROWNOUT_CONFIG_FIELD))
    begin
      next_cause[B_SBOR] = 1'b1; // RL13
    end
    if (TRAP_CONFLICT) next_cause[B_TRAP] = 1'b1; // RL7
    if (ILLEGAL_OPCODE || UNINIT_WREG) next_cause[B_ILLOP] = 1'b1; // RL7
    if (CONFIG_MISMATCH) next_cause[B_CM] = 1'b1; // RL7
    if (ext_evt) next_cause[B_EXTERNAL_PIN_FLAG] = 1'b1; // RL7
    if (RESET_INSTR) next_cause[B_SWR] = 1'b1; // RL7
    if (WDT_TIMEOUT) next_cause[B_WATCHDOG_TIMEOUT_FLAG] = 1'b1; // RL8
    if (POWER_SAVING_INSTRUCTION_SLEEP) next_cause[B_SLEEP] = 1'b1; // RL9
    if (POWER_SAVING_INSTRUCTION_IDLE) next_cause[B_IDLE] = 1'b1; // RL10
    if (bor_evt) next_cause[B_BOR] = 1'b1; // RL11
    next_cause = next_cause & CAUSE_IMPL;
  end

  // Cause register; only power-on reloads it, other resets just set flags
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      cause <= CAUSE_POR_VALUE; // RL4 RL12
      cause[B_SBOR] <= sw_bor(BROWNOUT_CONFIG_FIELD); // RL13
    end
    else
    begin
      cause <= next_cause; // RL3
    end
  end

  // Enables derived from the fuses and the software bits
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      WATCHDOG_ENABLE <= 1'b0;
      BROWNOUT_ENABLE <= 1'b0;
      PROGMEM_SLEEP_POWER <= 1'b0;
    end
    else
    begin
      WATCHDOG_ENABLE <= WATCHDOG_CONFIG_FUSE | cause[B_SOFT_WATCHDOG_ENABLE]; // RL14
      case (BROWNOUT_CONFIG_FIELD)
        BROWNOUT_CONFIG_FIELD_OFF: BROWNOUT_ENABLE <= 1'b0;
        BROWNOUT_CONFIG_FIELD_SW: BROWNOUT_ENABLE <= cause[B_SBOR]; // RL15
        BROWNOUT_CONFIG_FIELD_NOSLEEP: BROWNOUT_ENABLE <= ~in_sleep;
        default: BROWNOUT_ENABLE <= 1'b1;
      endcase
      PROGMEM_SLEEP_POWER <= cause[B_PROGMEM_SLEEP_POWER];
    end
  end

  // Event status: set wins over a write-one-to-clear in the same cycle
  always_comb
  begin
    next_status = evt_status;
    if (do_write && aw_addr == OFS_EVT_STATUS)
    begin
      next_status = evt_status & ~(w_data[EVT_W-1:0] & wmask32[EVT_W-1:0]);
    end
    next_status = next_status | evt_vec;
  end

  // Status, mask and interrupt line
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      evt_status <= EVT_ZERO;
      evt_mask <= EVT_ZERO;
      IRQ <= 1'b0;
    end
    else
    begin
      evt_status <= next_status;
      if (do_write && aw_addr == OFS_EVT_MASK)
      begin
        evt_mask <= (evt_mask & ~wmask32[EVT_W-1:0]) | (w_data[EVT_W-1:0] & wmask32[EVT_W-1:0]);
      end
      IRQ <= |(next_status & evt_mask);
    end
  end

  // Scratch has no reset at all, so it keeps its value through every reset
  always_ff @(posedge CLK)
  begin
    if (do_write && aw_addr == OFS_SCRATCH)
    begin
      scratch <= (scratch & ~wmask32) | (w_data & wmask32); // RL6
    end
  end

  // Write channels are taken independently, response after both
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= DATA_ZERO;
      w_strb <= 4'h0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end
    else
    begin
      AWREADY <= ~aw_held & ~(AWVALID & AWREADY) & ~BVALID;
      WREADY <= ~w_held & ~(WVALID & WREADY) & ~BVALID;
      if (AWVALID && AWREADY)
      begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= (aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (BVALID && BREADY)
      begin
        BVALID <= 1'b0;
      end
    end
  end

  // Read channel; one read at a time, data one cycle after the address
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= DATA_ZERO;
      RRESP <= RESP_OKAY;
    end
    else
    begin
      ARREADY <= ~RVALID & ~(ARVALID & ARREADY);
      if (ARVALID && ARREADY)
      begin
        RVALID <= 1'b1;
        RRESP <= RESP_OKAY;
        case (ARADDR)
          OFS_CAUSE:
          begin
            RDATA <= {16'h0000, cause};
            // Reads as zero outside software control
            RDATA[B_SBOR] <= cause[B_SBOR] & sw_bor(BROWNOUT_CONFIG_FIELD); // RL13
          end
          OFS_EVT_STATUS: RDATA <= {24'h000000, evt_status};
          OFS_EVT_MASK: RDATA <= {24'h000000, evt_mask};
          OFS_SCRATCH: RDATA <= scratch; // RL6
          default:
          begin
            RDATA <= DATA_ZERO;
            RRESP <= RESP_SLVERR;
          end
        endcase
      end
      else if (RVALID && RREADY)
      begin
        RVALID <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence pin_low3;
    EXT_PIN_RESET_N == 1'b0 [*3];
  endsequence

  system_reset_out_follow_a: assert property (any_src |=> SYSTEM_RESET_OUT) // RL1
    else $error("system reset missed an active source");
  pin_sync_a: assert property (pin_low3 |-> ##[0:1] SYSTEM_RESET_OUT) // RL16
    else $error("pin reset did not reach system reset");
  trap_flag_a: assert property (TRAP_CONFLICT |=> cause[B_TRAP]) // RL7
    else $error("trap flag not set");
  watchdog_timeout_flag_clear_a: assert property ((POWER_SAVING_INSTRUCTION_IDLE && !WDT_TIMEOUT && !do_write) // RL8
    |=> !cause[B_WATCHDOG_TIMEOUT_FLAG])
    else $error("watchdog flag not cleared by power saving");
  sleep_flag_a: assert property (POWER_SAVING_INSTRUCTION_SLEEP |=> cause[B_SLEEP]) // RL9
    else $error("sleep flag not set");
  idle_flag_a: assert property (POWER_SAVING_INSTRUCTION_IDLE |=> cause[B_IDLE]) // RL10
    else $error("idle flag not set");
  // A qualified brown-out both flags itself and holds the system in reset
  bor_flag_a: assert property (bor_evt |=> cause[B_BOR] && SYSTEM_RESET_OUT) // RL11
    else $error("brown-out flag not set");
  // Reset must be off through the whole window, so the enable register has settled before the check
  wdt_fuse_a: assert property ((RSTN && WATCHDOG_CONFIG_FUSE) [*2] |-> WATCHDOG_ENABLE) // RL14
    else $error("watchdog not forced on by fuse");
  bor_cfg_a: assert property ((BROWNOUT_CONFIG_FIELD == BROWNOUT_CONFIG_FIELD_OFF) |=> !BROWNOUT_ENABLE) // RL15
    else $error("brown-out enabled while configured off");
  sw_noreset_a: assert property ((!any_src && do_write) |=> !SYSTEM_RESET_OUT) // RL5
    else $error("software write caused a reset");
  // Brown-out enable bit follows the configuration field seen during power-on
  por_value_a: assert property (disable iff (1'b0) !RSTN |=> // RL4
    ({cause[15:B_SBOR+1], cause[B_SBOR-1:0]} ==
    {CAUSE_POR_VALUE[15:B_SBOR+1], CAUSE_POR_VALUE[B_SBOR-1:0]})
    && (cause[B_SBOR] == sw_bor($past(BROWNOUT_CONFIG_FIELD))))
    else $error("power-on cause value wrong");

endmodule : rscf_top

// File: sim/rscf_src_model.sv
`timescale 1ns/10ps
// Far side of the reset block: pin, comparator, watchdog and CPU event sources
module rscf_src_model (
  input wire logic clk, // System clock
  input wire logic fire, // Start one event
  input wire logic [3:0] sel, // Event to start, 15 starts none
  output logic pin_n, // External reset pin, pulled up while idle
  output logic [9:1] evt // Other sources, active high
);
  logic [3:0] sel_q; // Event being played
  logic [2:0] left = 3'h0; // Cycles of the event still to play

  // Pin and comparator are held a few cycles so they outlast the synchronisers
  always @(posedge clk)
  begin
    if (fire)
    begin
      sel_q <= sel;
      left <= (sel == 4'h0 || sel == 4'h3) ? 3'h4 : 3'h1;
    end
    else if (left != 3'h0)
      left <= left - 3'h1;
  end

  // Pin is open drain with a pull-up, so it reads high outside an event
  always_comb
  begin
    pin_n = !(left != 3'h0 && sel_q == 4'h0);
    for (int i = 1; i < 10; i++)
      evt[i] = left != 3'h0 && sel_q == i;
  end
endmodule : rscf_src_model

// File: sim/rscf_tb_top.sv
`timescale 1ns/10ps
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h want %h", $time, (g), (e)); end end
module rscf_tb_top;
  import rscf_pkg::*;
  typedef struct {
    int src;
    logic [15:0] pre;
    logic [15:0] cause;
    logic [7:0] evt;
    logic rst;
  } rscf_row_type;
  logic clk = 0, rstn = 0, fire = 0, fuse = 0, wakeup = 0;
  logic sys_rst, wdt_en, bor_en, pm_pwr, irq, pin_n, seen;
  logic [3:0] sel = 0, awaddr = 0, wstrb = 4'hF, araddr = 0;
  logic [9:1] evt;
  logic [1:0] field = BROWNOUT_CONFIG_FIELD_SW, bresp, rresp, rs;
  logic [31:0] wdata = 0, rdata, rd;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  int num_errors = 0;
  int compares = 0;
  // Event, cause before, cause after, event status after, reset seen
  rscf_row_type rows [10] = '{
    '{0, 16'h2000, 16'h2080, 8'h01, 1'b1}, '{1, 16'h2000, 16'h2040, 8'h02, 1'b1},
    '{2, 16'h2000, 16'h2010, 8'h04, 1'b1}, '{3, 16'h2000, 16'h2002, 8'h08, 1'b1},
    '{4, 16'h2000, 16'hA000, 8'h10, 1'b1}, '{5, 16'h2000, 16'h6000, 8'h20, 1'b1},
    '{6, 16'h2000, 16'h6000, 8'h40, 1'b1}, '{7, 16'h2000, 16'h2200, 8'h80, 1'b1},
    '{8, 16'h2010, 16'h2008, 8'h00, 1'b0}, '{9, 16'h2010, 16'h2004, 8'h00, 1'b0}};

  rscf_top rscf_top_i (.CLK(clk), .RSTN(rstn), .EXT_PIN_RESET_N(pin_n),
    .BROWNOUT_DETECT(evt[3]), .RESET_INSTR(evt[1]), .WDT_TIMEOUT(evt[2]),
    .TRAP_CONFLICT(evt[4]), .ILLEGAL_OPCODE(evt[5]), .UNINIT_WREG(evt[6]),
    .CONFIG_MISMATCH(evt[7]), .POWER_SAVING_INSTRUCTION_SLEEP(evt[8]), .POWER_SAVING_INSTRUCTION_IDLE(evt[9]),
    .WAKEUP(wakeup), .WATCHDOG_CONFIG_FUSE(fuse), .BROWNOUT_CONFIG_FIELD(field),
    .SYSTEM_RESET_OUT(sys_rst), .WATCHDOG_ENABLE(wdt_en), .BROWNOUT_ENABLE(bor_en),
    .PROGMEM_SLEEP_POWER(pm_pwr), .IRQ(irq), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready));

  rscf_src_model rscf_src_model_i (.clk(clk), .fire(fire), .sel(sel), .pin_n(pin_n),
    .evt(evt));

  // 40 MHz system clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // One write; address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1;
    w = 1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (aw || w)
    begin
      @(posedge clk);
      if (awready) aw = 0;
      if (wready) w = 0;
      awvalid <= aw;
      wvalid <= w;
    end
    do @(posedge clk); while (bvalid !== 1);
    r = bresp;
    bready <= 0;
    // Spare edge so the next call never drives bready twice in one step
    @(posedge clk);
  endtask : wr

  // One read; rready held until the data arrive
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (arready !== 1);
    arvalid <= 0;
    do @(posedge clk); while (rvalid !== 1);
    d = rdata;
    r = rresp;
    rready <= 0;
    @(posedge clk);
  endtask : rd_reg

  // Play one source event and note whether the system reset rose meanwhile
  task automatic trig(input int s);
    sel <= s[3:0];
    fire <= 1;
    @(posedge clk);
    fire <= 0;
    seen = 0;
    repeat (14)
    begin
      @(posedge clk);
      seen |= sys_rst;
    end
  endtask : trig

  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // Main sequence: table of sources first, then the awkward cases
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1;
    repeat (2) @(posedge clk);
    rd_reg(OFS_CAUSE, rd, rs);
    `CHECK(rd[15:0], 16'h2003)
    foreach (rows[i])
    begin
      wr(OFS_CAUSE, {16'h0, rows[i].pre}, rs);
      `CHECK(rs, RESP_OKAY)
      wr(OFS_EVT_STATUS, 32'hFF, rs);
      `CHECK(irq, 1'b0)
      trig(rows[i].src);
      `CHECK(seen, rows[i].rst)
      `CHECK(sys_rst, 1'b0)
      rd_reg(OFS_CAUSE, rd, rs);
      `CHECK(rd[15:0], rows[i].cause)
      rd_reg(OFS_EVT_STATUS, rd, rs);
      `CHECK(rd[7:0], rows[i].evt)
      wr(OFS_EVT_MASK, 32'hFF, rs);
      `CHECK(irq, |rows[i].evt)
    end
    // Every flag set by software, with no reset following
    wr(OFS_CAUSE, 32'hFFFF, rs);
    trig(15);
    `CHECK(seen, 1'b0)
    rd_reg(OFS_CAUSE, rd, rs);
    `CHECK(rd[15:0], CAUSE_IMPL)
    `CHECK(pm_pwr, 1'b1)
    `CHECK(wdt_en, 1'b1)
    // Software enables off: watchdog follows the fuse, brown-out is ignored
    wr(OFS_CAUSE, 32'h0, rs);
    `CHECK(wdt_en, 1'b0)
    `CHECK(bor_en, 1'b0)
    fuse <= 1;
    repeat (2) @(posedge clk);
    `CHECK(wdt_en, 1'b1)
    trig(3);
    `CHECK(seen, 1'b0)
    // Unreset storage survives a non power-on reset
    wr(OFS_SCRATCH, 32'hA55A3CC3, rs);
    trig(4);
    rd_reg(OFS_SCRATCH, rd, rs);
    `CHECK(rd, 32'hA55A3CC3)
    // Misaligned accesses are refused
    rd_reg(4'h2, rd, rs);
    `CHECK(rs, RESP_SLVERR)
    `CHECK(rd, DATA_ZERO)
    wr(4'h6, 32'h1, rs);
    `CHECK(rs, RESP_SLVERR)
    // Second power-on reset with software brown-out control disabled
    field <= BROWNOUT_CONFIG_FIELD_OFF;
    rstn <= 0;
    repeat (4) @(posedge clk);
    `CHECK(sys_rst, 1'b1)
    rstn <= 1;
    repeat (2) @(posedge clk);
    rd_reg(OFS_CAUSE, rd, rs);
    `CHECK(rd[15:0], CAUSE_POR_VALUE)
    wr(OFS_CAUSE, 32'h2000, rs);
    rd_reg(OFS_CAUSE, rd, rs);
    `CHECK(rd[15:0], 16'h0000)
    // Sleep-gated mode: detector off while asleep, back on after wake-up
    field <= BROWNOUT_CONFIG_FIELD_NOSLEEP;
    trig(8);
    `CHECK(bor_en, 1'b0)
    wakeup <= 1;
    @(posedge clk);
    wakeup <= 0;
    repeat (2) @(posedge clk);
    `CHECK(bor_en, 1'b1)
    complete_run();
  end

  // Whole run needs well under a thousand cycles; stop a hang long after that
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule : rscf_tb_top
